// file: common/xpt_pkg.sv
/*
  Shared constants, types and register map of the digital crosspoint block.
  Assumes a single 40 MHz clock and an AXI4-Lite register master.
*/
package xpt_pkg;
  localparam int NPIN = 8;  // I/O pins of the crosspoint
  localparam int NCTL = 2;  // Clock and control capable pins, one quarter of NPIN
  localparam int NGRP = 4;  // Route data input groups, two pins each

  // Register byte addresses
  localparam logic [7:0] A_CFG0 = 8'h00;  // Pin configs, one word per pin
  localparam logic [7:0] A_SIG  = 8'h20;  // User signature store
  localparam logic [7:0] A_ID   = 8'h24;  // Device identification, read only
  localparam logic [7:0] A_SEC  = 8'h28;  // Readback security bit
  localparam logic [7:0] A_CMD  = 8'h2c;  // Bulk erase command
  localparam logic [7:0] A_STAT = 8'h30;  // Live pin state, read only

  localparam logic [31:0] ID_VAL    = 32'h0000_5a01;  // Arbitrary value
  localparam logic [31:0] ERASE_KEY = 32'h0000_00e5;  // Word that starts a bulk erase
  localparam logic [31:0] SEC_PAT   = 32'h0000_0000;  // Returned for hidden reads
  localparam logic [31:0] SIG_RST   = 32'h0000_0000;
  localparam logic        SEC_RST   = 1'b0;
  localparam logic [1:0]  RESP_OK   = 2'b00;
  localparam logic [1:0]  RESP_ERR  = 2'b10;
  localparam int          CFG_W     = 18;

  typedef enum logic [1:0] {
    pin_off                 = 2'b00,
    static_pin_routing_mode = 2'b01,
    switch_emulation_mode   = 2'b10,
    dynamic_data_path_mode  = 2'b11
  } xpt_mode_t;

  // Per-pin configuration word, bit 0 upward: mode, src, level, grp_pick ...
  typedef struct packed {
    logic       regd;               // 17: register the data path value
    logic       clk_pol;            // 16: invert the selected clock
    logic [1:0] clk_src;            // 15:14: 0/1 control pin, 2/3 dedicated clock
    logic       oe_used;            // 13: dynamic output enable in use
    logic       oe_pin;             // 12: control pin driving the enable
    logic       route_select_bit1;  // 11: control pin of select bit 1
    logic       route_select_bit0;  // 10: control pin of select bit 0
    logic [3:0] grp_pick;           // 9:6: pin chosen within each data group
    logic       level;              // 5: constant level of switch mode
    logic [2:0] src;                // 4:2: source pin of static mode
    xpt_mode_t  mode;               // 1:0
  } xpt_cfg_t;

  localparam xpt_cfg_t CFG_RST = '0;
endpackage : xpt_pkg

// file: hdl/xpt_crosspoint.sv
/*
  Digital crosspoint: static routes, constant switch outputs and a dynamic
  4:1 data path per pin, plus a signature store and readback security.
  Assumes pin and dedicated clock inputs synchronous to aclk, and an
  AXI4-Lite master that keeps one write and one read in flight.
*/
`timescale 1ns/100ps
module xpt_crosspoint (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [7:0]                 awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [7:0]                 araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic [xpt_pkg::NPIN-1:0]   pin_i,
  output logic      [xpt_pkg::NPIN-1:0]   pin_o,
  output logic      [xpt_pkg::NPIN-1:0]   pin_oe,
  input  wire logic                       ded_clk
);
  import xpt_pkg::*;

  xpt_cfg_t          cfg_q [NPIN];
  xpt_cfg_t          cfg_d [NPIN];
  logic [31:0]       sig_q, sig_d;
  logic              sec_q, sec_d;
  logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0]        waddr_q, waddr_d;
  logic [31:0]       wdat_q, wdat_d;
  logic [3:0]        wstb_q, wstb_d;
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              bvalid_q, bvalid_d, arready_q, arready_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              do_wr, do_erase, ar_go;
  logic [NPIN-1:0]   pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
  logic [NPIN-1:0]   cap_q, cap_d, clv_q, clv_d, mux_v, clk_edge;

  // Register index of a config word, or NPIN when not a config address
  function automatic logic [3:0] cfg_idx(input logic [7:0] a);
    cfg_idx = (a < A_SIG) ? {1'b0, a[4:2]} : 4'(NPIN);
  endfunction : cfg_idx

  // Merge write data into a word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction : merge

  // Write channel acceptance and response
  always_comb begin
    aw_hold_d = aw_hold_q;
    waddr_d   = waddr_q;
    w_hold_d  = w_hold_q;
    wdat_d    = wdat_q;
    wstb_d    = wstb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    do_wr     = aw_hold_q && w_hold_q && !bvalid_q;
    if (awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      waddr_d   = awaddr;
    end
    if (wvalid && wready_q) begin
      w_hold_d = 1'b1;
      wdat_d   = wdata;
      wstb_d   = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (waddr_q[1:0] == 2'b00 && (cfg_idx(waddr_q) != 4'(NPIN)
                   || waddr_q == A_SIG || waddr_q == A_SEC || waddr_q == A_CMD))
                  ? RESP_OK : RESP_ERR;
    end
    awready_d = !aw_hold_d;
    wready_d  = !w_hold_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdat_q    <= 32'h0000_0000;
      wstb_q    <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OK;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      waddr_q   <= waddr_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // Configuration, signature and security updates
  always_comb begin
    do_erase = do_wr && waddr_q == A_CMD && merge(32'h0, wdat_q, wstb_q) == ERASE_KEY;
    sig_d    = sig_q;
    sec_d    = sec_q;
    for (int i = 0; i < NPIN; i++) begin
      cfg_d[i] = cfg_q[i];
      if (do_wr && cfg_idx(waddr_q) == 4'(i) && waddr_q[1:0] == 2'b00) begin
        cfg_d[i] = xpt_cfg_t'(CFG_W'(merge(32'(cfg_q[i]), wdat_q, wstb_q)));
      end
    end
    if (do_wr && waddr_q == A_SIG) begin
      sig_d = merge(sig_q, wdat_q, wstb_q);
    end
    if (do_wr && waddr_q == A_SEC && wstb_q[0] && wdat_q[0]) begin
      sec_d = 1'b1;
    end
    if (do_erase) begin
      sec_d = SEC_RST;
      sig_d = SIG_RST;
      for (int i = 0; i < NPIN; i++) begin
        cfg_d[i] = CFG_RST;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sig_q <= SIG_RST;
      sec_q <= SEC_RST;
      for (int i = 0; i < NPIN; i++) begin
        cfg_q[i] <= CFG_RST;
      end
    end else begin
      sig_q <= sig_d;
      sec_q <= sec_d;
      for (int i = 0; i < NPIN; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // Read channel: one cycle from address to data
  always_comb begin
    ar_go     = arvalid && arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_go) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OK;
      rdata_d  = 32'h0000_0000;
      if (araddr[1:0] != 2'b00) begin
        rresp_d = RESP_ERR;
      end else if (cfg_idx(araddr) != 4'(NPIN)) begin
        rdata_d = sec_q ? SEC_PAT : 32'(cfg_q[araddr[4:2]]);
      end else if (araddr == A_SIG) begin
        rdata_d = sig_q;
      end else if (araddr == A_ID) begin
        rdata_d = ID_VAL;
      end else if (araddr == A_SEC) begin
        rdata_d = {31'h0, sec_q};
      end else if (araddr == A_STAT) begin
        rdata_d = {8'h00, pin_oe_q, pin_o_q, pin_i};
      end else if (araddr != A_CMD) begin
        rresp_d = RESP_ERR;
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OK;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Pin routing: static, constant and dynamic data path per output pin
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      logic       cs;
      logic [1:0] s;
      logic [1:0] k;
      cs = cfg_q[i].clk_src[1] ? ded_clk : pin_i[cfg_q[i].clk_src[0]];
      clv_d[i]    = cs ^ cfg_q[i].clk_pol;
      clk_edge[i] = clv_d[i] && !clv_q[i];
      s = {pin_i[cfg_q[i].route_select_bit1],
           pin_i[cfg_q[i].route_select_bit0]};
      k = {s[1], s[1] ^ s[0]};                                       // Select code to input
      mux_v[i] = pin_i[{k, cfg_q[i].grp_pick[k]}];
      cap_d[i] = clk_edge[i] ? mux_v[i] : cap_q[i];
      unique case (cfg_q[i].mode)
        static_pin_routing_mode: begin
          pin_o_d[i]  = pin_i[cfg_q[i].src];
          pin_oe_d[i] = 1'b1;
        end
        switch_emulation_mode: begin
          pin_o_d[i]  = cfg_q[i].level;
          pin_oe_d[i] = 1'b1;
        end
        dynamic_data_path_mode: begin
          pin_o_d[i]  = cfg_q[i].regd ? cap_q[i] : mux_v[i];
          pin_oe_d[i] = !cfg_q[i].oe_used || pin_i[cfg_q[i].oe_pin];
        end
        pin_off: begin
          pin_o_d[i]  = 1'b0;
          pin_oe_d[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o_q  <= '0;
      pin_oe_q <= '0;
      cap_q    <= '0;
      clv_q    <= clv_d;  // Track the level so release shows no false edge
    end else begin
      pin_o_q  <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      cap_q    <= cap_d;
      clv_q    <= clv_d;
    end
  end

  // Outputs straight from flip-flops
  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign pin_o   = pin_o_q;
  assign pin_oe  = pin_oe_q;

  // Checks on every pin and the register port
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  for (genvar g = 0; g < NPIN; g++) begin : g_pin_chk
    AST_STATIC_ROUTE: assert property (
      cfg_q[g].mode == static_pin_routing_mode && $stable(cfg_q[g])
      |=> pin_oe_q[g] && pin_o_q[g] == $past(pin_i[cfg_q[g].src]))
      else $error("static route output wrong");
    AST_SWITCH_LEVEL: assert property (
      cfg_q[g].mode == switch_emulation_mode ##1 cfg_q[g].mode == switch_emulation_mode
      |-> pin_oe_q[g] && pin_o_q[g] == $past(cfg_q[g].level))
      else $error("switch level wrong");
    AST_PATH_MUX: assert property (
      cfg_q[g].mode == dynamic_data_path_mode && !cfg_q[g].regd
      |=> pin_o_q[g] == $past(mux_v[g]))
      else $error("data path select wrong");
    AST_PATH_OE: assert property (
      cfg_q[g].mode == dynamic_data_path_mode && cfg_q[g].oe_used
      && !pin_i[cfg_q[g].oe_pin] |=> !pin_oe_q[g])
      else $error("data path not tri-stated");
    AST_CLK_CAPTURE: assert property (
      clk_edge[g] |=> cap_q[g] == $past(mux_v[g]))
      else $error("capture on clock edge missed");
  end
  AST_SIG_READ: assert property (
    ar_go && araddr == A_SIG |=> rvalid_q && rdata_q == $past(sig_q))
    else $error("signature read wrong");
  AST_SEC_HIDE: assert property (
    ar_go && araddr < A_SIG && araddr[1:0] == 2'b00 && sec_q
    |=> rdata_q == SEC_PAT && rresp_q == RESP_OK)
    else $error("secure readback leaked");
  AST_ID_READ: assert property (
    ar_go && araddr == A_ID |=> rdata_q == ID_VAL)
    else $error("id read wrong");
  AST_SEC_STICKY: assert property (
    sec_q && !do_erase |=> sec_q)
    else $error("security bit cleared without erase");
  AST_WRITE_RESP: assert property (
    awvalid && awready_q && wvalid && wready_q && !bvalid_q |-> ##[1:2] bvalid_q)
    else $error("write response late");

  COV_SECURE_READ: cover property (ar_go && sec_q && araddr == A_CFG0);
  COV_ERASE: cover property (sec_q && do_erase);
  COV_REG_PATH: cover property (clk_edge[0] && cfg_q[0].regd
                                && cfg_q[0].mode == dynamic_data_path_mode);
endmodule : xpt_crosspoint

// file: tb/xpt_pin_driver.sv
/*
  Far-side model: control logic that drives the crosspoint pins.
  Assumes the bench sets the levels it wants on drv just after a clock edge.
*/
`timescale 1ns/100ps
module xpt_pin_driver (
  input  wire logic [xpt_pkg::NPIN-1:0] drv,
  input  wire logic [xpt_pkg::NPIN-1:0] pin_o,
  input  wire logic [xpt_pkg::NPIN-1:0] pin_oe,
  output logic      [xpt_pkg::NPIN-1:0] pin_i
);
  import xpt_pkg::*;

  // Wire level: the crosspoint wins while it drives, else the control logic
  // Selects sit on pins 0 and 1, data on one pin per group
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & drv);
endmodule : xpt_pin_driver

// file: tb/xpt_crosspoint_bench.sv
/*
  Self-checking bench of the crosspoint: register map, routes, security.
  Assumes a 40 MHz aclk and the pin driver model on the far side.
*/
`timescale 1ns/100ps
module xpt_crosspoint_bench;
  import xpt_pkg::*;
  logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ded_clk;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [7:0]      awaddr, araddr;
  logic [NPIN-1:0] drv, pin_i, pin_o, pin_oe;
  logic [31:0]     wdata, rdata, v;
  logic [1:0]      bresp, rresp, r;
  int              n_mismatch, n_tests;
  // Pin rows: drive levels {p4,p3,p2,sel1,sel0} and expected pin_o[7:5]
  logic [7:0]      p_drv [6] = '{8'h1c, 8'h01, 8'h05, 8'h1b, 8'h0b, 8'h16};
  logic [2:0]      p_exp [6] = '{3'b011, 3'b010, 3'b110, 3'b111, 3'b011, 3'b110};
  // Clock rows: drive levels, dedicated clock level, expected registered pin_o[7]
  logic [7:0]      c_drv [4] = '{8'h01, 8'h05, 8'h05, 8'h01};
  logic [3:0]      c_clk = 4'b0101;
  logic [3:0]      c_exp = 4'b0100;

  xpt_crosspoint u_xpt_crosspoint (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .ded_clk(ded_clk)
  );

  xpt_pin_driver u_xpt_pin_driver (.drv(drv), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

  // Clock, 25 ns period
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 200) n_mismatch++;
  endtask : wr

  // AXI4-Lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 200) n_mismatch++;
  endtask : rd

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Watchdog well beyond the expected run length
  initial begin
    #(25 * 20000);
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ded_clk} = '0;
    awaddr  = '0;
    araddr  = '0;
    wdata   = '0;
    drv     = '0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({29'h0, awready, wready, arready}, 32'h7);
    rd(A_SIG, v, r);
    chk(v, SIG_RST);
    rd(A_SEC, v, r);
    chk(v, {31'h0, SEC_RST});
    $display("test reset done");
    // Pin 5 static from pin 3, pin 6 fixed high, pin 7 path with selects on pins 0,1
    wr(A_CFG0 + 8'h14, 32'h0000_000d, r);
    wr(A_CFG0 + 8'h18, 32'h0000_0022, r);
    wr(A_CFG0 + 8'h1c, 32'hfffc_0803, r);
    chk({30'h0, r}, {30'h0, RESP_OK});
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      drv <= p_drv[i];
      @(posedge aclk);
      #1;
      chk({24'h0, pin_o}, {24'h0, p_exp[i], 5'h0});
      chk({24'h0, pin_oe}, 32'h0000_00e0);
    end
    $display("test routes done");
    // Dynamic output enable from pin 0
    wr(A_CFG0 + 8'h1c, 32'h0000_2803, r);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      drv <= 8'(k);
      @(posedge aclk);
      #1;
      chk({31'h0, pin_oe[7]}, 32'(k));
    end
    rd(A_CFG0 + 8'h1c, v, r);
    chk(v, 32'h0000_2803);
    $display("test tristate done");
    // Security set: configuration hidden, signature and identity still readable
    wr(A_SIG, 32'h1234_abcd, r);
    wr(A_SEC, 32'h0000_0001, r);
    rd(A_CFG0 + 8'h1c, v, r);
    chk(v, SEC_PAT);
    chk({30'h0, r}, {30'h0, RESP_OK});
    rd(A_SIG, v, r);
    chk(v, 32'h1234_abcd);
    rd(A_ID, v, r);
    chk(v, ID_VAL);
    wr(A_SEC, 32'h0000_0000, r);
    wr(A_CMD, 32'h0000_0001, r);
    rd(A_SEC, v, r);
    chk(v, 32'h0000_0001);
    wr(A_CMD, ERASE_KEY, r);
    rd(A_SEC, v, r);
    chk(v, 32'h0000_0000);
    rd(A_SIG, v, r);
    chk(v, SIG_RST);
    chk({24'h0, pin_oe}, 32'h0);
    $display("test security done");
    // Refused accesses
    wr(A_ID, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, RESP_ERR});
    rd(A_ID, v, r);
    chk(v, ID_VAL);
    rd(8'h34, v, r);
    chk({r, v[29:0]}, {RESP_ERR, 30'h0});
    rd(8'h21, v, r);
    chk({30'h0, r}, {30'h0, RESP_ERR});
    $display("test refusals done");
    // Registered path on the dedicated clock, then with the clock inverted
    wr(A_CFG0 + 8'h1c, 32'h0002_8803, r);
    for (int s = 0; s < 4; s++) begin
      @(posedge aclk);
      drv     <= c_drv[s];
      ded_clk <= c_clk[s];
      repeat (3) @(posedge aclk);
      #1;
      chk({31'h0, pin_o[7]}, {31'h0, c_exp[s]});
      if (s == 2) wr(A_CFG0 + 8'h1c, 32'h0003_8803, r);
    end
    rd(A_STAT, v, r);
    chk(v, 32'h0080_0001);
    $display("test clock select done");
    // Reset in mid-run: outputs clear, then the port answers again
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    chk({11'h0, pin_oe, pin_o, awready, wready, arready, bvalid, rvalid}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({29'h0, awready, wready, arready}, 32'h7);
    rd(A_CFG0 + 8'h1c, v, r);
    chk(v, {14'h0, CFG_RST});
    $display("test reset in run done");
    summarize();
  end
endmodule : xpt_crosspoint_bench
